// >>> hdl/cpr_pkg.sv
// package: calibration pattern readout constants and types
package cpr_pkg;
    // command decode on the registered command bus
    typedef enum logic [2:0] {
        CPR_CMD_NOP,
        CPR_CMD_MRS,
        CPR_CMD_RD,
        CPR_CMD_WR,
        CPR_CMD_OTHER
    } cpr_cmd_t;

    typedef struct packed {
        cpr_cmd_t    cmd;
        logic [2:0]  mrSel;      // mode register number for MRS
        logic [15:0] addr;       // address / opcode bits
        logic        chopOtf;    // burst chop 4 selected on the fly
    } cpr_req_t;

    typedef struct packed {
        logic [15:0] dq;         // x16 lanes, one beat
        logic        fromMpr;    // beat came from the calibration register
        logic        last;       // last beat of the burst
    } cpr_beat_t;

    localparam logic [2:0] CPR_MR3        = 3'h3;
    localparam int         CPR_MPR_EN_BIT = 2;
    localparam int         CPR_LOC_LO     = 0;
    localparam int         CPR_LOC_HI     = 1;
    localparam int         CPR_NIBBLE_BIT = 2;
    localparam int         CPR_AP_BIT     = 10;
    localparam logic [1:0] CPR_BUF_FULL   = 2'h2;
    localparam logic [7:0] CPR_LANE0_ONLY = 8'h01;
    localparam logic [1:0] CPR_LOC_PATTERN = 2'h0;
    localparam logic [1:0] CPR_LOC_RST    = 2'h0;
    localparam logic [3:0] CPR_BL8_BEATS  = 4'h8;
    localparam logic [3:0] CPR_BC4_BEATS  = 4'h4;
    localparam logic [3:0] CPR_WR_LAG_BL8 = 4'h4;
    localparam logic [3:0] CPR_WR_LAG_BC4 = 4'h2;
    localparam logic [7:0] CPR_PATTERN    = 8'hAA;   // beat order 0..7: 0,1,0,1...
    localparam logic [7:0] CPR_BYTE_ZERO  = 8'h00;
    localparam logic [7:0] CPR_BYTE_ONES  = 8'hFF;
endpackage

// >>> hdl/cpr_calibration_pattern_readout.sv
// calibration register read redirection inside the memory device
`timescale 1ns/100ps
// Summary of operation
// - MRS to MR3 with enable bit one enters calibration readout mode.
// - in readout mode every RD or RDA is served from the calibration register.
// - two-bit location field in MR3 is stored, but reads do not decode it; every location returns the same pattern.
// - RDA acts as plain read in readout mode; auto-precharge is ignored.
// - reset stays effective while readout mode is enabled.
// - enable bit clear means normal array reads and writes, location ignored.
// - internal write starts WL plus four, or plus two for fixed BC4.
// - location zero returns alternating zero, one pattern across the burst.
// - lane bit zero of each byte carries data; others copy it or drive zero.
module cpr_calibration_pattern_readout (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              reqValid,
    input  cpr_pkg::cpr_req_t      req,
    input  wire logic [3:0]        readLatency,
    input  wire logic [3:0]        writeLatency,
    input  wire logic              chopFixed,
    input  wire logic              copyLane0,
    input  wire logic [15:0]       arrayData,
    output logic                   arrayRead,
    output logic                   arrayPrecharge,
    output logic                   writeStart,
    output logic                   mprMode,
    output logic [1:0]             mprLoc,
    output logic                   beatValid,
    output cpr_pkg::cpr_beat_t     beat,
    input  wire logic              beatReady
);
    import cpr_pkg::*;

    typedef enum {CPR_IDLE, CPR_WAIT, CPR_BURST} cpr_state_t;

    function automatic logic [15:0] laneFill(input logic bit0, input logic copy);
        logic [7:0] b;
        b = bit0 ? (copy ? CPR_BYTE_ONES : CPR_LANE0_ONLY) : CPR_BYTE_ZERO;
        return {b, b};
    endfunction

    // mode register state
    logic       mprEn_ff, nxt_mprEn;
    logic [1:0] loc_ff, nxt_loc;
    // read sequencer
    cpr_state_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [3:0] beatIdx_ff, nxt_beatIdx;
    logic [3:0] beats_ff, nxt_beats;
    logic       srcMpr_ff, nxt_srcMpr;
    logic       arrRd_ff, nxt_arrRd;
    logic       arrPre_ff, nxt_arrPre;
    // write start delay
    logic [3:0] wrCnt_ff, nxt_wrCnt;
    logic       wrBusy_ff, nxt_wrBusy;
    logic       wrStart_ff, nxt_wrStart;
    // two-entry skid buffer
    cpr_beat_t  buf_ff [2], nxt_buf [2];
    logic [1:0] bufCnt_ff, nxt_bufCnt;
    logic       rdPtr_ff, nxt_rdPtr;
    logic       wrPtr_ff, nxt_wrPtr;
    // head of the buffer registered so the outputs come straight from flops
    logic       beatVld_ff, nxt_beatVld;
    cpr_beat_t  beatOut_ff, nxt_beatOut;

    logic       isRead, isWrite, isMr3, pushOk, push, pop;
    cpr_beat_t  newBeat;

    always_comb begin
        isRead  = reqValid && req.cmd == CPR_CMD_RD;
        isWrite = reqValid && req.cmd == CPR_CMD_WR;
        isMr3   = reqValid && req.cmd == CPR_CMD_MRS && req.mrSel == CPR_MR3;
        nxt_mprEn = mprEn_ff;
        nxt_loc   = loc_ff;
        if (isMr3) begin
            nxt_mprEn = req.addr[CPR_MPR_EN_BIT];
            nxt_loc   = req.addr[CPR_LOC_HI:CPR_LOC_LO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mprEn_ff <= 1'b0;
            loc_ff   <= CPR_LOC_RST;
        end else begin
            mprEn_ff <= nxt_mprEn;
            loc_ff   <= nxt_loc;
        end
    end

    // buffer bookkeeping
    assign pushOk = bufCnt_ff != CPR_BUF_FULL;
    assign pop    = beatValid && beatReady;

    // a stalled receiver freezes the burst rather than dropping beats
    always_comb begin
        nxt_st      = st_ff;
        nxt_cnt     = cnt_ff;
        nxt_beatIdx = beatIdx_ff;
        nxt_beats   = beats_ff;
        nxt_srcMpr  = srcMpr_ff;
        nxt_arrRd   = 1'b0;
        nxt_arrPre  = 1'b0;
        push        = 1'b0;
        newBeat     = '0;
        case (st_ff)
            CPR_IDLE: begin
                if (isRead) begin
                    nxt_srcMpr = mprEn_ff;
                    nxt_arrRd  = !mprEn_ff;
                    // auto-precharge only acts on array reads
                    nxt_arrPre = !mprEn_ff && req.addr[CPR_AP_BIT];
                    nxt_beats  = (chopFixed || req.chopOtf) ? CPR_BC4_BEATS : CPR_BL8_BEATS;
                    // nibble select for chopped reads, column bits 1:0 assumed zero
                    nxt_beatIdx = (chopFixed || req.chopOtf) && req.addr[CPR_NIBBLE_BIT]
                                  ? CPR_BC4_BEATS : 4'h0;
                    nxt_cnt    = readLatency;
                    nxt_st     = CPR_WAIT;
                end
            end
            CPR_WAIT: begin
                if (cnt_ff <= 4'h1) begin
                    nxt_st  = CPR_BURST;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            CPR_BURST: begin
                if (pushOk) begin
                    push = 1'b1;
                    newBeat.fromMpr = srcMpr_ff;
                    if (srcMpr_ff) begin
                        // reserved locations return the pattern too, so no location decode here
                        newBeat.dq = laneFill(CPR_PATTERN[beatIdx_ff[2:0]], copyLane0);
                    end else begin
                        newBeat.dq = arrayData;
                    end
                    newBeat.last = cnt_ff == beats_ff - 4'h1;
                    nxt_cnt      = cnt_ff + 4'h1;
                    nxt_beatIdx  = beatIdx_ff + 4'h1;
                    if (newBeat.last) begin
                        nxt_st = CPR_IDLE;
                    end
                end
            end
            default: nxt_st = CPR_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff      <= CPR_IDLE;
            cnt_ff     <= 4'h0;
            beatIdx_ff <= 4'h0;
            beats_ff   <= CPR_BL8_BEATS;
            srcMpr_ff  <= 1'b0;
            arrRd_ff   <= 1'b0;
            arrPre_ff  <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            cnt_ff     <= nxt_cnt;
            beatIdx_ff <= nxt_beatIdx;
            beats_ff   <= nxt_beats;
            srcMpr_ff  <= nxt_srcMpr;
            arrRd_ff   <= nxt_arrRd;
            arrPre_ff  <= nxt_arrPre;
        end
    end

    // internal write start, writes only reach the array with readout mode off
    always_comb begin
        nxt_wrCnt   = wrCnt_ff;
        nxt_wrBusy  = wrBusy_ff;
        nxt_wrStart = 1'b0;
        if (wrBusy_ff) begin
            if (wrCnt_ff <= 4'h1) begin
                nxt_wrBusy  = 1'b0;
                nxt_wrStart = 1'b1;
            end else begin
                nxt_wrCnt = wrCnt_ff - 4'h1;
            end
        end else if (isWrite && !mprEn_ff) begin
            nxt_wrBusy = 1'b1;
            nxt_wrCnt  = writeLatency + (chopFixed ? CPR_WR_LAG_BC4 : CPR_WR_LAG_BL8);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrCnt_ff   <= 4'h0;
            wrBusy_ff  <= 1'b0;
            wrStart_ff <= 1'b0;
        end else begin
            wrCnt_ff   <= nxt_wrCnt;
            wrBusy_ff  <= nxt_wrBusy;
            wrStart_ff <= nxt_wrStart;
        end
    end

    always_comb begin
        nxt_buf    = buf_ff;
        nxt_wrPtr  = wrPtr_ff;
        nxt_rdPtr  = rdPtr_ff;
        nxt_bufCnt = bufCnt_ff;
        if (push) begin
            nxt_buf[wrPtr_ff] = newBeat;
            nxt_wrPtr         = !wrPtr_ff;
        end
        if (pop) begin
            nxt_rdPtr = !rdPtr_ff;
        end
        if (push && !pop) begin
            nxt_bufCnt = bufCnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_bufCnt = bufCnt_ff - 2'h1;
        end
        nxt_beatVld = nxt_bufCnt != 2'h0;
        nxt_beatOut = nxt_buf[nxt_rdPtr];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
            bufCnt_ff <= 2'h0;
            beatVld_ff <= 1'b0;
            beatOut_ff <= '0;
            rdPtr_ff  <= 1'b0;
            wrPtr_ff  <= 1'b0;
        end else begin
            buf_ff    <= nxt_buf;
            beatVld_ff <= nxt_beatVld;
            beatOut_ff <= nxt_beatOut;
            bufCnt_ff <= nxt_bufCnt;
            rdPtr_ff  <= nxt_rdPtr;
            wrPtr_ff  <= nxt_wrPtr;
        end
    end

    assign arrayRead      = arrRd_ff;
    assign arrayPrecharge = arrPre_ff;
    assign writeStart     = wrStart_ff;
    assign mprMode        = mprEn_ff;
    assign mprLoc         = loc_ff;
    assign beatValid      = beatVld_ff;
    assign beat           = beatOut_ff;
endmodule

// >>> verif/cpr_checker_assertions.sv
// assertions on the calibration readout block ports
`timescale 1ns/100ps
module cpr_checker (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          reqValid,
    input cpr_pkg::cpr_req_t  req,
    input wire logic          copyLane0,
    input wire logic          arrayRead,
    input wire logic          arrayPrecharge,
    input wire logic          mprMode,
    input wire logic [1:0]    mprLoc,
    input wire logic          beatValid,
    input cpr_pkg::cpr_beat_t beat,
    input wire logic          beatReady
);
    import cpr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence mrsMr3; reqValid && req.cmd == CPR_CMD_MRS && req.mrSel == CPR_MR3; endsequence
    sequence mprRead; reqValid && req.cmd == CPR_CMD_RD && mprMode; endsequence
    AST_ENTER: assert property (mrsMr3 ##0 req.addr[CPR_MPR_EN_BIT] |=> mprMode)
        else $error("mode not entered");
    AST_EXIT: assert property (mrsMr3 ##0 !req.addr[CPR_MPR_EN_BIT] |=> !mprMode)
        else $error("mode not left");
    AST_LOC: assert property (mrsMr3 ##0 req.addr[CPR_MPR_EN_BIT] |=> mprLoc == $past(req.addr[1:0]))
        else $error("location not stored");
    AST_NO_ARRAY: assert property (mprRead |=> !arrayRead)
        else $error("array read in readout mode");
    AST_NO_PRECHARGE: assert property (mprRead ##0 req.addr[10] |=> !arrayPrecharge)
        else $error("precharge in readout mode");
    // both bytes carry the same bit; upper bits copy it or stay low
    AST_LANE: assert property (beatValid && beat.fromMpr |-> beat.dq[15:8] == beat.dq[7:0] &&
        beat.dq[7:1] == (copyLane0 ? {7{beat.dq[0]}} : 7'h00)) else $error("lane fill wrong");
    AST_HOLD: assert property (beatValid && !beatReady |=> beatValid && $stable(beat))
        else $error("stalled beat lost");
    AST_RESET: assert property (disable iff (1'b0) rst |=> !mprMode && !beatValid && mprLoc == 2'h0)
        else $error("reset not honoured");
    AST_ARRAY_CAUSE: assert property (arrayRead |-> $past(reqValid && req.cmd == CPR_CMD_RD && !mprMode))
        else $error("array read without a plain read");
    AST_PRECHARGE_CAUSE: assert property (arrayPrecharge |-> arrayRead && $past(req.addr[CPR_AP_BIT]))
        else $error("precharge without auto-precharge read");
endmodule

// >>> verif/cpr_ctrl_model.sv
// controller-side model issuing commands into the readout block
`timescale 1ns/100ps
module cpr_ctrl_model #(
    parameter int IDLE_GAP = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    output logic              reqValid,
    output cpr_pkg::cpr_req_t req
);
    import cpr_pkg::*;
    logic mprOn;
    initial {reqValid, req, mprOn} = '0;
    always @(posedge rst) mprOn = 1'b0;
    // dll held locked for the whole run, so reads are always legal
    task automatic issue(input cpr_cmd_t cmd, input logic [2:0] sel, input logic [15:0] addr, input logic chop);
        if (mprOn && cmd != CPR_CMD_RD && cmd != CPR_CMD_MRS) return;
        if (cmd == CPR_CMD_MRS) repeat (IDLE_GAP) @(posedge clk);
        @(posedge clk);
        #1;
        reqValid = 1'b1;
        req      = '{cmd, sel, (cmd == CPR_CMD_RD) ? {addr[15:2], 2'h0} : addr, chop};
        mprOn    = (cmd == CPR_CMD_MRS && sel == CPR_MR3) ? addr[CPR_MPR_EN_BIT] : mprOn;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        // idle lines carry junk rather than the last command
        req      = cpr_req_t'(23'($urandom));
    endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the calibration readout block
`timescale 1ns/100ps
module testbench;
    import cpr_pkg::*;
    logic        clk, rst, reqValid, chopFixed, copyLane0, beatReady, stall, modeOn;
    logic        arrayRead, arrayPrecharge, writeStart, mprMode, beatValid;
    logic [3:0]  readLatency, writeLatency;
    logic [15:0] arrayData;
    logic [1:0]  mprLoc;
    cpr_req_t    req;
    cpr_beat_t   beat;
    cpr_beat_t   expQ[$];
    int          err_total, check_count, stallCnt, k;
    cpr_calibration_pattern_readout i_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
        .readLatency(readLatency), .writeLatency(writeLatency), .chopFixed(chopFixed), .copyLane0(copyLane0),
        .arrayData(arrayData), .arrayRead(arrayRead), .arrayPrecharge(arrayPrecharge), .writeStart(writeStart),
        .mprMode(mprMode), .mprLoc(mprLoc), .beatValid(beatValid), .beat(beat), .beatReady(beatReady));
    cpr_ctrl_model i_ctrl (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req));
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // expected beats are queued before the read goes out; the monitor pops them
    task automatic rd(input logic chop, input logic hi, input logic ap);
        logic       b;
        logic [7:0] y;
        arrayData = 16'($urandom);
        for (int i = 0; i < (chop ? 4 : 8); i++) begin
            b = 1'(i + ((chop && hi) ? 4 : 0));
            y = copyLane0 ? {8{b}} : {7'h00, b};
            expQ.push_back({modeOn ? {y, y} : arrayData, modeOn, 1'(i == (chop ? 3 : 7))});
        end
        i_ctrl.issue(CPR_CMD_RD, 3'h0, {5'($urandom), ap, 7'($urandom), hi, 2'h0}, chop);
        check("array read", 18'(arrayRead), 18'(!modeOn));
        check("precharge", 18'(arrayPrecharge), 18'(!modeOn && ap));
        for (int n = 0; n < 300 && expQ.size() > 0; n++) @(posedge clk);
        check("burst done", 18'(expQ.size()), 18'h0);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic mrs(input logic en, input logic [1:0] loc);
        i_ctrl.issue(CPR_CMD_MRS, CPR_MR3, {13'h0000, en, loc}, 1'b0);
        modeOn = en;
        @(posedge clk);
        #1;
        check("mode", 18'(mprMode), 18'(en));
        if (en) check("loc", 18'(mprLoc), 18'(loc));
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    // a stall window lets the two-entry buffer fill and refuse
    // beats are compared at the falling edge, where beat and ready have settled
    always @(negedge clk) begin
        if (!rst && beatValid === 1'b1 && beatReady === 1'b1)
            check("beat", beat, expQ.size() > 0 ? 18'(expQ.pop_front()) : 18'bX);
    end
    always @(posedge clk) begin
        #1;
        stallCnt = stall ? stallCnt + 1 : 0;
        beatReady = !(stall && stallCnt < 24) && ($urandom % 4 != 0);
    end
    initial begin
        void'($urandom(32'h50B8FC71));
        {rst, stall, modeOn, beatReady, chopFixed, copyLane0} = 6'h20;
        {arrayData, readLatency, writeLatency} = 24'h000034;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(1'b0, 1'b0, 1'b1);
        rd(1'b1, 1'b1, 1'b0);
        for (int f = 0; f < 2; f++) begin
            chopFixed = f[0];
            writeLatency = 4'(1 + $urandom % 8);
            i_ctrl.issue(CPR_CMD_WR, 3'h0, 16'($urandom), 1'b0);
            for (k = 0; k < 40 && writeStart !== 1'b1; k++) begin
                @(posedge clk);
                #1;
            end
            check("write lag", 18'(k), 18'(writeLatency + (f ? 2 : 4)));
        end
        chopFixed = 1'b0;
        for (int l = 0; l < 4; l++) begin
            readLatency = 4'(1 + $urandom % 6);
            copyLane0 = l[0];
            mrs(1'b1, 2'(l));
            stall = (l == 1);
            rd(1'b0, 1'b0, l[1]);
            rd(1'b1, 1'b0, 1'b1);
            rd(1'b1, 1'b1, 1'b0);
        end
        mrs(1'b0, 2'h3);
        rd(1'b0, 1'b0, 1'b1);
        mrs(1'b1, 2'h1);
        rst = 1'b1;
        @(posedge clk);
        #1;
        {rst, modeOn} = 2'h0;
        check("reset mode", 18'({mprMode, mprLoc}), 18'h0);
        rd(1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
bind cpr_calibration_pattern_readout cpr_checker i_chk (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
    .copyLane0(copyLane0), .arrayRead(arrayRead), .arrayPrecharge(arrayPrecharge), .mprMode(mprMode),
    .mprLoc(mprLoc), .beatValid(beatValid), .beat(beat), .beatReady(beatReady));
